/* File: verilog/cpu_regs_pkg.sv */
package cpu_regs_pkg;
    // Data path width and register count
    localparam int REG_W = 16;
    localparam int NUM_REGS = 16;
    // Register indices with fixed roles
    localparam logic [3:0] IDX_PC = 4'h0;
    localparam logic [3:0] IDX_SP = 4'h1;
    localparam logic [3:0] IDX_SR = 4'h2;
    localparam logic [3:0] IDX_CG = 4'h3;
    localparam int FIRST_GPR = 4;
    // Status word bit positions
    localparam int SR_C = 0;
    localparam int SR_Z = 1;
    localparam int SR_N = 2;
    localparam int SR_GIE = 3;
    localparam int SR_HALT = 4;
    localparam int SR_CRYSTAL_HALT = 5;
    localparam int SR_DC_GEN_SHUTDOWN = 6;
    localparam int SR_SUBSYSTEM_CLOCK_SHUTDOWN = 7;
    localparam int SR_V = 8;
    // Implemented status bits; 15 to 9 read as zero
    localparam logic [15:0] SR_MASK = 16'h01FF;
    // Reset values
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [15:0] SR_RST = 16'h0000;
    localparam logic [15:0] GPR_RST = 16'h0000;
    // Stack step in bytes
    localparam logic [15:0] STACK_STEP = 16'h0002;
    // Word alignment mask
    localparam logic [15:0] ALIGN_MASK = 16'hFFFE;
    localparam logic [15:0] LOW_BYTE = 16'h00FF;
    // Source operand mode field encodings
    localparam logic [1:0] MODE_REG = 2'h0;
    localparam logic [1:0] MODE_IDX = 2'h1;
    localparam logic [1:0] MODE_IND = 2'h2;
    localparam logic [1:0] MODE_INC = 2'h3;
    // Generated constants
    localparam logic [15:0] CG_ZERO = 16'h0000;
    localparam logic [15:0] CG_ONE = 16'h0001;
    localparam logic [15:0] CG_TWO = 16'h0002;
    localparam logic [15:0] CG_FOUR = 16'h0004;
    localparam logic [15:0] CG_EIGHT = 16'h0008;
    localparam logic [15:0] CG_MINUS1 = 16'hFFFF;
    // Flag update kinds from the ALU
    localparam logic [1:0] OP_LOGIC = 2'h0;
    localparam logic [1:0] OP_ADD = 2'h1;
    localparam logic [1:0] OP_SUB = 2'h2;
endpackage : cpu_regs_pkg

/* File: verilog/const_gen.sv */
`timescale 1ns/100ps
module const_gen
    import cpu_regs_pkg::*;
(
    // Source selection
    input wire logic [3:0] src_reg_i,
    input wire logic [1:0] src_mode_i,
    // Generated constant
    output logic cg_hit_o,
    output logic abs_zero_o,
    output logic [15:0] cg_value_o
);
    // Decode constant source from register and mode
    always_comb begin
        cg_hit_o = 1'b0;
        abs_zero_o = 1'b0;
        cg_value_o = CG_ZERO;
        if (src_reg_i == IDX_SR) begin
            unique case (src_mode_i)
                MODE_REG: cg_hit_o = 1'b0;
                // Zero base, absolute address word still follows
                MODE_IDX: abs_zero_o = 1'b1;
                MODE_IND: begin
                    cg_hit_o = 1'b1;
                    cg_value_o = CG_FOUR;
                end
                MODE_INC: begin
                    cg_hit_o = 1'b1;
                    cg_value_o = CG_EIGHT;
                end
            endcase
        end else if (src_reg_i == IDX_CG) begin
            cg_hit_o = 1'b1;
            unique case (src_mode_i)
                MODE_REG: cg_value_o = CG_ZERO;
                MODE_IDX: cg_value_o = CG_ONE;
                MODE_IND: cg_value_o = CG_TWO;
                MODE_INC: cg_value_o = CG_MINUS1;
            endcase
        end
    end
endmodule : const_gen

/* File: verilog/flag_calc.sv */
`timescale 1ns/100ps
module flag_calc
    import cpu_regs_pkg::*;
(
    // ALU operands and result
    input wire logic [15:0] dst_val_i,
    input wire logic [15:0] src_val_i,
    input wire logic [15:0] result_i,
    input wire logic carry_i,
    input wire logic [1:0] op_kind_i,
    input wire logic byte_i,
    // Flags
    output logic neg_o,
    output logic zero_o,
    output logic carry_o,
    output logic ovf_o
);
    logic sd;
    logic ss;
    logic sr;
    logic [15:0] res_m;

    // Sign bits follow operand size
    always_comb begin
        res_m = byte_i ? (result_i & LOW_BYTE) : result_i;
        sd = byte_i ? dst_val_i[7] : dst_val_i[15];
        ss = byte_i ? src_val_i[7] : src_val_i[15];
        sr = byte_i ? result_i[7] : result_i[15];
    end

    assign neg_o = sr;
    assign zero_o = (res_m == CG_ZERO);
    assign carry_o = carry_i;

    // Overflow only meaningful for add and subtract kinds
    always_comb begin
        ovf_o = 1'b0;
        if (op_kind_i == OP_ADD) begin
            ovf_o = (sd == ss) && (sr != sd);
        end
        if (op_kind_i == OP_SUB) begin
            ovf_o = (sd != ss) && (sr != sd);
        end
    end
endmodule : flag_calc

/* File: verilog/cpu_register_file.sv */
// Behaviour
// - Sixteen 16-bit registers; 4 to 15 general, byte or word access.
// - Instruction pointer advances by instruction length: two, four or six bytes.
// - Fetches only on word boundaries across the full 64 KB space.
// - Instruction pointer always even; bit 0 held zero.
// - Instruction pointer usable as operand; writing it branches.
// - Stack pointer predecrements on push, postincrements on pop.
// - Stack pointer kept even; bit 0 reads zero.
// - Pushing the stack pointer still moves it like any push.
// - Popping into stack pointer loads popped word, no post-increment.
// - Status word is plain operand only in word register mode.
// - Add overflow: like signs giving opposite sign result.
// - Subtract overflow: positive minus negative negative, or reverse.
// - Subsystem clock shutdown bit requests subsystem clock off.
// - Dc generator shutdown requested only when digital oscillator unused.
// - Crystal halt requested only when crystal oscillator unused.
// - Processor halt bit stops instruction execution.
// - Global interrupt enable gates maskable interrupts.
// - Negative flag copies bit 15 or bit 7 by size.
// - Zero flag set when sized result is zero.
// - Carry flag reflects carry out of the operation.
// - Registers 2 and 3 generate constants from source mode bits.
// - Constant registers act only as sources, not stored values.
// - Byte writes zero the upper byte, except to the status word, which ignores them; flags follow byte result.
// - Interrupt entry clears halt, subsystem shutdown and crystal halt.
`timescale 1ns/100ps
module cpu_register_file
    import cpu_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Source read port
    input wire logic [3:0] src_reg_i,
    input wire logic [1:0] src_mode_i,
    output logic [15:0] src_data_o,
    output logic cg_hit_o,
    output logic abs_zero_o,
    // Destination read port
    input wire logic [3:0] dst_reg_i,
    output logic [15:0] dst_data_o,
    // Write port
    input wire logic wr_en_i,
    input wire logic [3:0] wr_reg_i,
    input wire logic wr_byte_i,
    input wire logic [15:0] wr_data_i,
    // Instruction pointer advance
    input wire logic pc_adv_i,
    input wire logic [1:0] instr_words_i,
    // Stack control
    input wire logic sp_push_i,
    input wire logic sp_pop_i,
    output logic [15:0] sp_addr_o,
    // Flag update from the ALU
    input wire logic flag_upd_i,
    input wire logic [1:0] op_kind_i,
    input wire logic op_byte_i,
    input wire logic [15:0] alu_dst_i,
    input wire logic [15:0] alu_src_i,
    input wire logic [15:0] alu_res_i,
    input wire logic alu_carry_i,
    // Interrupt entry
    input wire logic irq_entry_i,
    // Clock system status
    input wire logic dco_in_use_i,
    input wire logic lfxt_in_use_i,
    // Register views
    output logic [15:0] instr_pointer_o,
    output logic [15:0] stack_ptr_o,
    output logic [15:0] status_word_o,
    // Control outputs
    output logic processor_halt_o,
    output logic global_irq_enable_o,
    output logic subsystem_clock_shutdown_o,
    output logic dc_gen_shutdown_o,
    output logic crystal_halt_o
);
    // Register storage
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic [15:0] sp_q;
    logic [15:0] sp_d;
    logic [15:0] sr_q;
    logic [15:0] sr_d;
    logic [15:0] gpr_q [FIRST_GPR:NUM_REGS-1];
    logic dc_shut_q;
    logic xtal_halt_q;

    // Write decode
    logic [15:0] wr_val;
    logic wr_pc;
    logic wr_sp;
    logic wr_sr;
    logic [15:0] pc_step;

    // Flag and constant helpers
    logic f_neg;
    logic f_zero;
    logic f_carry;
    logic f_ovf;
    logic [15:0] cg_value;

    assign wr_val = wr_byte_i ? (wr_data_i & LOW_BYTE) : wr_data_i;

    assign wr_pc = wr_en_i && (wr_reg_i == IDX_PC);
    assign wr_sp = wr_en_i && (wr_reg_i == IDX_SP);
    assign wr_sr = wr_en_i && (wr_reg_i == IDX_SR) && !wr_byte_i;

    // Instruction length in bytes is twice the word count
    assign pc_step = {13'h0000, instr_words_i, 1'b0};

    // Constant generator decode
    const_gen u_const_gen (
        .src_reg_i(src_reg_i),
        .src_mode_i(src_mode_i),
        .cg_hit_o(cg_hit_o),
        .abs_zero_o(abs_zero_o),
        .cg_value_o(cg_value)
    );

    // Flag generation for the sized result
    flag_calc u_flag_calc (
        .dst_val_i(alu_dst_i),
        .src_val_i(alu_src_i),
        .result_i(alu_res_i),
        .carry_i(alu_carry_i),
        .op_kind_i(op_kind_i),
        .byte_i(op_byte_i),
        .neg_o(f_neg),
        .zero_o(f_zero),
        .carry_o(f_carry),
        .ovf_o(f_ovf)
    );

    // Read mux shared by both ports
    function automatic logic [15:0] read_reg(input logic [3:0] idx);
        logic [15:0] val;
        val = CG_ZERO;
        unique case (idx)
            IDX_PC: val = pc_q;
            IDX_SP: val = sp_q;
            IDX_SR: val = sr_q;
            IDX_CG: val = CG_ZERO;
            default: val = gpr_q[idx];
        endcase
        return val;
    endfunction : read_reg

    always_comb begin
        src_data_o = read_reg(src_reg_i);
        if (cg_hit_o) begin
            src_data_o = cg_value;
        end
        if (abs_zero_o) begin
            src_data_o = CG_ZERO;
        end
    end

    always_comb begin
        dst_data_o = read_reg(dst_reg_i); // A process, so stored values wake it too
    end

    // Instruction pointer next value; a branch beats the advance
    always_comb begin
        pc_d = pc_q;
        if (wr_pc) begin
            pc_d = wr_val & ALIGN_MASK;
        end else if (pc_adv_i && !sr_q[SR_HALT]) begin
            pc_d = (pc_q + pc_step) & ALIGN_MASK;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pc_q <= PC_RST;
        end else begin
            pc_q <= pc_d;
        end
    end

    // Stack pointer next value; a write wins over push and pop
    always_comb begin
        sp_d = sp_q;
        if (wr_sp) begin
            sp_d = wr_val & ALIGN_MASK;
        end else if (sp_push_i) begin
            sp_d = sp_q - STACK_STEP;
        end else if (sp_pop_i) begin
            sp_d = sp_q + STACK_STEP;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sp_q <= SP_RST;
        end else begin
            sp_q <= sp_d & ALIGN_MASK;
        end
    end

    assign sp_addr_o = sp_push_i ? (sp_q - STACK_STEP) : sp_q;

    // Status word next value; a word write beats flags and interrupt entry
    always_comb begin
        sr_d = sr_q;
        if (wr_sr) begin
            sr_d = wr_val & SR_MASK;
        end else begin
            if (flag_upd_i) begin
                sr_d[SR_N] = f_neg;
                sr_d[SR_Z] = f_zero;
                sr_d[SR_C] = f_carry;
                sr_d[SR_V] = f_ovf;
            end
            if (irq_entry_i) begin
                sr_d[SR_HALT] = 1'b0;
                sr_d[SR_SUBSYSTEM_CLOCK_SHUTDOWN] = 1'b0;
                sr_d[SR_CRYSTAL_HALT] = 1'b0;
            end
        end
    end

    // Status register storage
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sr_q <= SR_RST;
        end else begin
            sr_q <= sr_d;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = FIRST_GPR; i < NUM_REGS; i++) begin
                gpr_q[i] <= GPR_RST;
            end
        end else begin
            for (int i = FIRST_GPR; i < NUM_REGS; i++) begin
                if (wr_en_i && (wr_reg_i == 4'(i))) begin
                    gpr_q[i] <= wr_val;
                end
            end
        end
    end

    // Oscillator requests are gated by use so a live clock is never cut
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dc_shut_q <= 1'b0;
            xtal_halt_q <= 1'b0;
        end else begin
            dc_shut_q <= sr_d[SR_DC_GEN_SHUTDOWN] && !dco_in_use_i;
            xtal_halt_q <= sr_d[SR_CRYSTAL_HALT] && !lfxt_in_use_i;
        end
    end

    // Register views
    assign instr_pointer_o = pc_q;
    assign stack_ptr_o = sp_q;
    assign status_word_o = sr_q;

    assign processor_halt_o = sr_q[SR_HALT];
    assign global_irq_enable_o = sr_q[SR_GIE];
    assign subsystem_clock_shutdown_o = sr_q[SR_SUBSYSTEM_CLOCK_SHUTDOWN];
    assign dc_gen_shutdown_o = dc_shut_q;
    assign crystal_halt_o = xtal_halt_q;

    // Checks on the register behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_pc_even: assert property (pc_q[0] == 1'b0)
        else $error("instruction pointer odd");

    chk_sp_even: assert property (sp_q[0] == 1'b0)
        else $error("stack pointer odd");

    chk_pc_advance: assert property (
        pc_adv_i && !wr_pc && !sr_q[SR_HALT]
        |=> pc_q == (($past(pc_q) + $past(pc_step)) & ALIGN_MASK))
        else $error("pointer advance wrong");

    chk_pc_branch: assert property (
        wr_pc |=> pc_q == ($past(wr_val) & ALIGN_MASK))
        else $error("branch target not loaded");

    chk_sp_push: assert property (
        sp_push_i && !wr_sp |=> sp_q == $past(sp_q) - STACK_STEP)
        else $error("push did not predecrement");

    chk_pop_self: assert property (
        sp_pop_i && wr_sp |=> sp_q == ($past(wr_val) & ALIGN_MASK))
        else $error("pop into stack pointer incremented");

    chk_halt_hold: assert property (
        sr_q[SR_HALT] && !wr_pc |=> $stable(pc_q))
        else $error("pointer moved while halted");

    chk_irq_clear: assert property (
        irq_entry_i && !wr_sr
        |=> !sr_q[SR_HALT] && !sr_q[SR_SUBSYSTEM_CLOCK_SHUTDOWN] && !sr_q[SR_CRYSTAL_HALT])
        else $error("interrupt entry left low power bits");

    chk_cg_minus1: assert property (
        src_reg_i == IDX_CG && src_mode_i == MODE_INC |-> src_data_o == CG_MINUS1)
        else $error("constant minus one wrong");

    chk_dc_gate: assert property (
        dco_in_use_i |=> !dc_shut_q)
        else $error("dc generator shut while in use");

    chk_crystal_gate: assert property (
        lfxt_in_use_i |=> !xtal_halt_q)
        else $error("crystal halted while in use");

    chk_sp_pop: assert property (
        sp_pop_i && !sp_push_i && !wr_sp |=> sp_q == $past(sp_q) + STACK_STEP)
        else $error("pop did not postincrement");

    chk_sr_reserved: assert property (sr_q[15:9] == 7'h00)
        else $error("reserved status bits set");

    // Main scenarios
    cov_push_pop: cover property (sp_push_i ##1 sp_pop_i);
    cov_pop_self: cover property (sp_pop_i && wr_sp);
    cov_irq_wake: cover property (sr_q[SR_HALT] ##1 irq_entry_i);
    cov_branch: cover property (wr_pc && pc_adv_i);
endmodule : cpu_register_file

/* File: test/stack_mem_model.sv */
`timescale 1ns/100ps
module stack_mem_model (
    // Clock
    input wire logic clk_i,
    // Word port
    input wire logic wr_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem_q [256];
    logic [255:0] vld_q = '0;
    // Word store; byte address bit 0 is ignored; plain always since vld_q has an initial value
    always @(posedge clk_i) begin
        if (wr_i) begin
            mem_q[addr_i[8:1]] <= wdata_i;
            vld_q[addr_i[8:1]] <= 1'b1;
        end
    end
    // Unwritten words show a pattern, not a stale value
    assign rdata_o = vld_q[addr_i[8:1]] ? mem_q[addr_i[8:1]] : ~addr_i;
endmodule : stack_mem_model

/* File: test/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import cpu_regs_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b1;
    logic [3:0] src_reg_i = 4'h0, dst_reg_i = 4'h0, wr_reg_i = 4'h0;
    logic [1:0] src_mode_i = 2'h0, instr_words_i = 2'h1, op_kind_i = 2'h0;
    logic wr_en_i = 0, wr_byte_i = 0, pc_adv_i = 0, sp_push_i = 0, sp_pop_i = 0, flag_upd_i = 0;
    logic op_byte_i = 0, alu_carry_i = 0, irq_entry_i = 0, dco_in_use_i = 0, lfxt_in_use_i = 0;
    logic [15:0] wr_data_i = 16'h0000, alu_dst_i = 16'h0000, alu_src_i = 16'h0000, alu_res_i = 16'h0000;
    logic [15:0] push_data = 16'h0000, mem_rd, src_data_o, dst_data_o, sp_addr_o;
    logic [15:0] instr_pointer_o, stack_ptr_o, status_word_o, e;
    logic cg_hit_o, abs_zero_o, processor_halt_o, global_irq_enable_o;
    logic subsystem_clock_shutdown_o, dc_gen_shutdown_o, crystal_halt_o;
    int miscompares = 0, n_compared = 0;
    // Constant table: register, mode, value
    logic [3:0] cr [7] = '{4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3};
    logic [1:0] cm [7] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3};
    logic [15:0] cv [7] = '{16'h0000, 16'h0004, 16'h0008, 16'h0000, 16'h0001, 16'h0002, 16'hFFFF};
    // Flag cases: kind, byte, dst, src, result, carry
    logic [1:0] fk [8] = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_SUB, OP_LOGIC, OP_LOGIC};
    logic fb [8] = '{0, 1, 0, 0, 0, 1, 0, 1};
    logic [15:0] fd [8] = '{16'h7FFF, 16'h007F, 16'h8000, 16'h8000, 16'h0001, 16'h0005, 16'h1234, 16'h00FF};
    logic [15:0] fs [8] = '{16'h0001, 16'h0001, 16'h8000, 16'h0001, 16'h8000, 16'h0003, 16'h0000, 16'h0000};
    logic [15:0] fr [8] = '{16'h8000, 16'h0080, 16'h0000, 16'h7FFF, 16'h8001, 16'h0002, 16'h0000, 16'hFF00};
    logic fc [8] = '{0, 0, 1, 1, 0, 1, 0, 0};

    // Free-running 100 MHz clock
    always #5 clk_i = ~clk_i;

    cpu_register_file cpu_register_file_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .src_reg_i(src_reg_i), .src_mode_i(src_mode_i), .src_data_o(src_data_o), .cg_hit_o(cg_hit_o),
        .abs_zero_o(abs_zero_o), .dst_reg_i(dst_reg_i), .dst_data_o(dst_data_o), .wr_en_i(wr_en_i),
        .wr_reg_i(wr_reg_i), .wr_byte_i(wr_byte_i), .wr_data_i(wr_data_i), .pc_adv_i(pc_adv_i),
        .instr_words_i(instr_words_i), .sp_push_i(sp_push_i), .sp_pop_i(sp_pop_i), .sp_addr_o(sp_addr_o),
        .flag_upd_i(flag_upd_i), .op_kind_i(op_kind_i), .op_byte_i(op_byte_i), .alu_dst_i(alu_dst_i),
        .alu_src_i(alu_src_i), .alu_res_i(alu_res_i), .alu_carry_i(alu_carry_i), .irq_entry_i(irq_entry_i),
        .dco_in_use_i(dco_in_use_i), .lfxt_in_use_i(lfxt_in_use_i), .instr_pointer_o(instr_pointer_o),
        .stack_ptr_o(stack_ptr_o), .status_word_o(status_word_o), .processor_halt_o(processor_halt_o),
        .global_irq_enable_o(global_irq_enable_o), .subsystem_clock_shutdown_o(subsystem_clock_shutdown_o),
        .dc_gen_shutdown_o(dc_gen_shutdown_o), .crystal_halt_o(crystal_halt_o));

    stack_mem_model stack_mem_model_inst (.clk_i(clk_i), .wr_i(sp_push_i), .addr_i(sp_addr_o),
        .wdata_i(push_data), .rdata_o(mem_rd));

    task automatic tally_and_finish();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Write one register; an idle cycle follows so a second call never
    // raises the strobe in the time step that lowered it
    task automatic wr(input logic [3:0] r, input logic b, input logic [15:0] d);
        wr_en_i = 1'b1;
        wr_reg_i = r;
        wr_byte_i = b;
        wr_data_i = d;
        @(negedge clk_i);
        wr_en_i = 1'b0;
        wr_byte_i = 1'b0;
        @(negedge clk_i);
    endtask : wr

    // Read through the destination port, compared at the next falling edge
    task automatic rd(input logic [3:0] r, input logic [15:0] exp);
        dst_reg_i = r;
        @(negedge clk_i);
        chk(dst_data_o, exp);
    endtask : rd

    // Hang guard
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(negedge clk_i);
        sys_rst_i = 0;
        chk(instr_pointer_o, PC_RST);
        chk(stack_ptr_o, SP_RST);
        chk(status_word_o, SR_RST);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            src_reg_i = cr[i];
            src_mode_i = cm[i];
            @(negedge clk_i);
            chk(src_data_o, cv[i]);
            chk({14'h0, cg_hit_o, abs_zero_o}, (cr[i] == 4'h2 && cm[i] == 2'h1) ? 16'h1 : 16'h2);
        end
        $display("test constants done");
        for (int r = 4; r < 16; r++) wr(r[3:0], 0, 16'hA500 | 16'(r));
        for (int r = 4; r < 16; r++) rd(r[3:0], 16'hA500 | 16'(r));
        wr(4'h4, 1, 16'h1234);
        rd(4'h4, 16'h0034);
        wr(IDX_CG, 0, 16'h5555);
        rd(IDX_CG, 16'h0000);
        rd(4'h4, 16'h0034);
        src_reg_i = 4'h7;
        src_mode_i = MODE_REG;
        @(negedge clk_i);
        chk(src_data_o, 16'hA507);
        $display("test registers done");
        wr(IDX_PC, 0, 16'h1235);
        chk(instr_pointer_o, 16'h1234);
        src_reg_i = IDX_PC;
        @(negedge clk_i);
        chk(src_data_o, 16'h1234);
        e = 16'h1234;
        // Advance held high across three lengths in a row
        pc_adv_i = 1'b1;
        for (int w = 1; w < 4; w++) begin
            instr_words_i = w[1:0];
            @(negedge clk_i);
            e = e + 16'(2 * w);
            chk(instr_pointer_o, e);
        end
        pc_adv_i = 1'b0;
        wr(IDX_PC, 0, 16'hFFFE);
        pc_adv_i = 1'b1;
        instr_words_i = 2'h1;
        @(negedge clk_i);
        pc_adv_i = 1'b0;
        chk(instr_pointer_o, 16'h0000);
        $display("test pointer done");
        // push, push of pointer, pop into pointer, plain pop
        wr(IDX_SP, 0, 16'h0401);
        chk(stack_ptr_o, 16'h0400);
        sp_push_i = 1'b1;
        push_data = 16'hBEEF;
        #1 chk(sp_addr_o, 16'h03FE);
        @(negedge clk_i);
        // Second push stores the pointer itself
        push_data = stack_ptr_o;
        chk(stack_ptr_o, 16'h03FE);
        @(negedge clk_i);
        sp_push_i = 1'b0;
        chk(stack_ptr_o, 16'h03FC);
        // Idle cycle so the model's read data has settled on the popped word
        @(negedge clk_i);
        sp_pop_i = 1'b1;
        wr_en_i = 1'b1;
        wr_reg_i = IDX_SP;
        wr_data_i = mem_rd;
        @(negedge clk_i);
        chk(stack_ptr_o, 16'h03FE);
        wr_reg_i = 4'h5;
        wr_data_i = mem_rd;
        @(negedge clk_i);
        sp_pop_i = 1'b0;
        wr_en_i = 1'b0;
        chk(stack_ptr_o, 16'h0400);
        rd(4'h5, 16'hBEEF);
        $display("test stack done");
        for (int i = 0; i < 8; i++) begin
            logic sd, ss, sr, v;
            logic [15:0] mask;
            wr(IDX_SR, 0, 16'h0008);
            flag_upd_i = 1'b1;
            op_kind_i = fk[i];
            op_byte_i = fb[i];
            alu_dst_i = fd[i];
            alu_src_i = fs[i];
            alu_res_i = fr[i];
            alu_carry_i = fc[i];
            @(negedge clk_i);
            flag_upd_i = 1'b0;
            sd = fb[i] ? fd[i][7] : fd[i][15];
            ss = fb[i] ? fs[i][7] : fs[i][15];
            sr = fb[i] ? fr[i][7] : fr[i][15];
            v = (fk[i] == OP_ADD) ? (sd == ss && sr != sd) : (sd != ss && sr != sd);
            e = 16'h0008 | (16'(v) << SR_V) | (16'(sr) << SR_N) | (16'(fc[i]) << SR_C);
            e = e | (16'((fb[i] ? fr[i][7:0] == 8'h00 : fr[i] == 16'h0000)) << SR_Z);
            mask = (fk[i] == OP_LOGIC) ? 16'h000F : 16'h010F;
            chk(status_word_o & mask, e & mask);
        end
        $display("test flags done");
        // control bits, halt, clock requests, interrupt entry
        wr(IDX_SR, 0, 16'hFFFF);
        chk(status_word_o, SR_MASK);
        wr(IDX_SR, 1, 16'h0000);
        chk(status_word_o, SR_MASK);
        chk({13'h0, processor_halt_o, global_irq_enable_o, subsystem_clock_shutdown_o}, 16'h7);
        chk({14'h0, dc_gen_shutdown_o, crystal_halt_o}, 16'h3);
        // Pointer was left at zero by the wrap test
        pc_adv_i = 1'b1;
        dco_in_use_i = 1'b1;
        repeat (2) @(negedge clk_i);
        pc_adv_i = 1'b0;
        chk(instr_pointer_o, 16'h0000);
        chk({14'h0, dc_gen_shutdown_o, crystal_halt_o}, 16'h1);
        irq_entry_i = 1'b1;
        @(negedge clk_i);
        irq_entry_i = 1'b0;
        dco_in_use_i = 1'b0;
        chk(status_word_o, 16'h014F);
        @(negedge clk_i);
        chk({13'h0, processor_halt_o, dc_gen_shutdown_o, crystal_halt_o}, 16'h2);
        lfxt_in_use_i = 1'b1;
        wr(IDX_SR, 0, 16'h0020);
        chk({15'h0, crystal_halt_o}, 16'h0);
        $display("test control done");
        // Mid-run reset clears the state built up by the tests
        sys_rst_i = 1'b1;
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk(status_word_o, SR_RST);
        chk(stack_ptr_o, SP_RST);
        rd(4'h5, GPR_RST);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule : testbench
